//--- src/nt_activation_fsm.sv
`timescale 1ns/1ps
// Operation
// - idle state G1 carries no data and sends INFO0.
// - pending activation G2 sends INFO2 and waits for INFO3.
// - activated state G3 sends INFO4.
// - T2 is zero, so G4 collapses into G1.
// - deactivate command in G2 or G3 goes straight to G1.
// - power-down senses line energy but never identifies the INFO.
// - any nonzero T2 lies strictly between 25 ms and 100 ms.
// - optional 100 ms hold after INFO3 before INFO4 and activation notice.
// - INFO0 declared only after 48 consecutive binary ones.
// - INFO0 in G3 gives INFO2 no sooner than 250 us later.
// - events queue until read; INFO levels are always observable.
// - deactivate and error indications to management may be suppressed.
// - INFO3 while pending raises the activation-pending event.
// - second activate command after that event enters G3.
module nt_activation_fsm #(
    parameter int GUARD_CYCLES = nt_act_pkg::GUARD_CYCLES,
    parameter int HOLD_CYCLES = nt_act_pkg::HOLD_CYCLES,
    parameter int T2_MS = nt_act_pkg::T2_MS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [nt_act_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [nt_act_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [nt_act_pkg::DATA_W-1:0] hrdata,
    // line receiver view
    input wire nt_act_pkg::line_rx_s line_rx,
    // line transmitter and processor attention
    output nt_act_pkg::info_e tx_info,
    output logic irq
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    initial begin
        if (T2_MS != 0 && (T2_MS <= nt_act_pkg::T2_MIN_MS || T2_MS >= nt_act_pkg::T2_MAX_MS))
            $error("nt_activation_fsm: T2_MS outside the open range 25..100 ms");
        if (T2_MS != 0)
            $error("nt_activation_fsm: only T2_MS = 0 is served, G4 is folded into G1");
        if (GUARD_CYCLES < 1 || HOLD_CYCLES < 1)
            $error("nt_activation_fsm: timer counts must be at least one");
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    localparam int TW = 24;

    nt_act_pkg::act_state_e state;
    nt_act_pkg::act_state_e next_state;
    nt_act_pkg::info_e next_tx_info;
    nt_act_pkg::events_s events;
    nt_act_pkg::events_s next_events;
    nt_act_pkg::events_s ev_set;

    logic dp_active;
    logic next_dp_active;
    logic dp_write;
    logic next_dp_write;
    logic [nt_act_pkg::REG_SEL_W-1:0] dp_addr;
    logic [nt_act_pkg::REG_SEL_W-1:0] next_dp_addr;
    logic rd_wait;
    logic next_rd_wait;
    logic [nt_act_pkg::DATA_W-1:0] next_hrdata;

    logic [7:0] last_cmd;
    logic [7:0] next_last_cmd;
    logic [1:0] config_bits;
    logic [1:0] next_config_bits;
    logic cmd_valid;
    logic event_read;
    logic hold_en;
    logic err_en;

    logic info1_prev;
    logic sig_prev;
    logic next_info1_prev;
    logic next_sig_prev;

    logic info0_seen;
    logic guard_load;
    logic guard_done;
    logic hold_load;
    logic hold_done;
    logic addr_phase;

    // ****************************************************************
    // ahb-lite slave
    // ****************************************************************

    // address phase taken only while the bus is ready and a transfer is live
    assign addr_phase = hsel && hready && htrans[1];

    // writes finish with no wait state; reads insert one so hrdata is a flop
    always_comb begin
        next_dp_active = dp_active;
        next_dp_write = dp_write;
        next_dp_addr = dp_addr;
        next_rd_wait = 1'b0;
        next_hrdata = hrdata;
        if (dp_active && !dp_write && !rd_wait) begin
            next_rd_wait = 1'b1;
            unique case (dp_addr)
                nt_act_pkg::REG_CMD: next_hrdata = {24'h00_0000, last_cmd};
                nt_act_pkg::REG_STATUS: begin
                    next_hrdata = '0;
                    next_hrdata[nt_act_pkg::ST_STATE_LSB +: 3] = state;
                    next_hrdata[nt_act_pkg::ST_TX_LSB +: 2] = tx_info;
                    next_hrdata[nt_act_pkg::ST_INFO0_BIT] = info0_seen;
                    next_hrdata[nt_act_pkg::ST_SIG_BIT] = line_rx.signal_present;
                    next_hrdata[nt_act_pkg::ST_LOCK_BIT] = line_rx.frame_lock;
                end
                nt_act_pkg::REG_EVENT: next_hrdata = {27'h000_0000, events};
                nt_act_pkg::REG_CONFIG: next_hrdata = {30'h0000_0000, config_bits};
                default: next_hrdata = 32'h0000_0000;   // unmapped reads as zero
            endcase
        end
        if (hreadyout) begin
            next_dp_active = addr_phase;
            next_dp_write = hwrite;
            next_dp_addr = haddr[nt_act_pkg::REG_SEL_W-1:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dp_active <= 1'b0;
            dp_write <= 1'b0;
            dp_addr <= '0;
            rd_wait <= 1'b0;
            hrdata <= '0;
        end else begin
            dp_active <= next_dp_active;
            dp_write <= next_dp_write;
            dp_addr <= next_dp_addr;
            rd_wait <= next_rd_wait;
            hrdata <= next_hrdata;
        end
    end

    assign hreadyout = !(dp_active && !dp_write && !rd_wait);
    assign hresp = 1'b0;   // always okay; hsize is not checked, word access assumed

    // write strobes and the read-to-clear of the event queue
    assign cmd_valid = dp_active && dp_write && (dp_addr == nt_act_pkg::REG_CMD);
    assign event_read = dp_active && !dp_write && !rd_wait && (dp_addr == nt_act_pkg::REG_EVENT);

    // ****************************************************************
    // software registers
    // ****************************************************************

    // last command is kept for read-back so the driver can check its order
    always_comb begin
        next_last_cmd = last_cmd;
        next_config_bits = config_bits;
        if (cmd_valid) next_last_cmd = hwdata[7:0];
        if (dp_active && dp_write && dp_addr == nt_act_pkg::REG_CONFIG)
            next_config_bits = hwdata[1:0];
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            last_cmd <= nt_act_pkg::CMD_NOP;
            config_bits <= nt_act_pkg::CFG_RESET;
        end else begin
            last_cmd <= next_last_cmd;
            config_bits <= next_config_bits;
        end
    end

    assign hold_en = config_bits[nt_act_pkg::CFG_HOLD_BIT];
    assign err_en = config_bits[nt_act_pkg::CFG_ERR_BIT];

    // ****************************************************************
    // line helpers
    // ****************************************************************
    info0_detect #(
        .ONES(nt_act_pkg::INFO0_ONES)
    ) u_info0 (
        .sys_clk(sys_clk),
        .rst(rst),
        .bit_val(line_rx.bit_val),
        .bit_valid(line_rx.bit_valid),
        .detected(info0_seen)
    );

    delay_timer #(
        .CYCLES(GUARD_CYCLES),
        .W(TW)
    ) u_guard (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(guard_load),
        .done(guard_done)
    );

    delay_timer #(
        .CYCLES(HOLD_CYCLES),
        .W(TW)
    ) u_hold (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(hold_load),
        .done(hold_done)
    );

    // edge memories so a standing level raises only one event
    always_comb begin
        next_info1_prev = line_rx.info1;
        next_sig_prev = line_rx.signal_present;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            info1_prev <= 1'b0;
            sig_prev <= 1'b0;
        end else begin
            info1_prev <= next_info1_prev;
            sig_prev <= next_sig_prev;
        end
    end

    // ****************************************************************
    // activation state machine
    // ****************************************************************

    // commands are acted on in the cycle their write data phase completes
    always_comb begin
        next_state = state;
        ev_set = '0;
        guard_load = 1'b0;
        hold_load = 1'b0;
        unique case (state)
            nt_act_pkg::PWR_DOWN: begin
                // only energy is sensed here, not which info it is
                if (line_rx.signal_present && !sig_prev) ev_set.line_detect = 1'b1;
                if (cmd_valid && hwdata[7:0] == nt_act_pkg::CMD_POWER_UP)
                    next_state = nt_act_pkg::G1_IDLE;
            end
            nt_act_pkg::G1_IDLE: begin
                if (line_rx.info1 && !info1_prev) ev_set.line_detect = 1'b1;
                if (cmd_valid && hwdata[7:0] == nt_act_pkg::CMD_ACTIVATE)
                    next_state = nt_act_pkg::G2_WAIT;
                else if (cmd_valid && hwdata[7:0] == nt_act_pkg::CMD_POWER_DOWN)
                    next_state = nt_act_pkg::PWR_DOWN;
            end
            nt_act_pkg::G2_WAIT: begin
                if (line_rx.info3) begin
                    next_state = nt_act_pkg::G2_PEND;
                    ev_set.act_pending = 1'b1;
                    hold_load = 1'b1;
                end
            end
            nt_act_pkg::G2_PEND: begin
                if (cmd_valid && hwdata[7:0] == nt_act_pkg::CMD_ACTIVATE) begin
                    if (hold_en && !hold_done) begin
                        next_state = nt_act_pkg::G2_ARMED;
                    end else begin
                        next_state = nt_act_pkg::G3_ACTIVE;
                        ev_set.activated = 1'b1;
                    end
                end
            end
            nt_act_pkg::G2_ARMED: begin
                // info4 and the activation notice wait for the hold-off
                if (hold_done) begin
                    next_state = nt_act_pkg::G3_ACTIVE;
                    ev_set.activated = 1'b1;
                end
            end
            nt_act_pkg::G3_ACTIVE: begin
                if (info0_seen || !line_rx.frame_lock) begin
                    next_state = nt_act_pkg::G2_GUARD;
                    guard_load = 1'b1;
                    ev_set.deactivated = err_en;
                    ev_set.error = err_en;
                end
            end
            nt_act_pkg::G2_GUARD: begin
                // info2 must not follow info0 too quickly
                if (guard_done) next_state = nt_act_pkg::G2_WAIT;
            end
            default: next_state = nt_act_pkg::G1_IDLE;  // three-bit code has a spare value
        endcase
        // with T2 at zero, deactivation lands in G1 at once, no G4
        if (cmd_valid && hwdata[7:0] == nt_act_pkg::CMD_DEACTIVATE &&
            state != nt_act_pkg::PWR_DOWN && state != nt_act_pkg::G1_IDLE) begin
            next_state = nt_act_pkg::G1_IDLE;
            ev_set.deactivated = 1'b1;
            guard_load = 1'b0;
        end
    end

    // the transmitted info is a function of the state being entered
    always_comb begin
        unique case (next_state)
            nt_act_pkg::G2_WAIT, nt_act_pkg::G2_PEND, nt_act_pkg::G2_ARMED:
                next_tx_info = nt_act_pkg::INFO2;
            nt_act_pkg::G3_ACTIVE: next_tx_info = nt_act_pkg::INFO4;
            default: next_tx_info = nt_act_pkg::INFO0;
        endcase
    end

    // queued events: a new event wins over the clear of the same read
    always_comb begin
        next_events = event_read ? nt_act_pkg::events_s'('0) : events;
        next_events = next_events | ev_set;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= nt_act_pkg::PWR_DOWN;
            tx_info <= nt_act_pkg::INFO0;
            events <= '0;
        end else begin
            state <= next_state;
            tx_info <= next_tx_info;
            events <= next_events;
        end
    end

    // attention line stays up while any event waits to be read
    assign irq = |events;

endmodule : nt_activation_fsm

//--- src/nt_act_pkg.sv
package nt_act_pkg;

    // ****************************************************************
    // bus geometry and register map
    // ****************************************************************
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CMD = 8'h00;     // command byte, reads back last one
    localparam logic [7:0] REG_STATUS = 8'h04;  // live state and line view
    localparam logic [7:0] REG_EVENT = 8'h08;   // queued events, cleared when read
    localparam logic [7:0] REG_CONFIG = 8'h0C;  // options
    localparam int REG_SEL_W = 8;

    // ****************************************************************
    // command byte encodings
    // ****************************************************************
    localparam logic [7:0] CMD_POWER_UP = 8'h01;
    localparam logic [7:0] CMD_POWER_DOWN = 8'h02;
    localparam logic [7:0] CMD_ACTIVATE = 8'h03;
    localparam logic [7:0] CMD_DEACTIVATE = 8'h04;
    localparam logic [7:0] CMD_NOP = 8'hFF;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int ST_STATE_LSB = 0;   // status [2:0] state code
    localparam int ST_TX_LSB = 4;      // status [5:4] info being sent
    localparam int ST_INFO0_BIT = 8;   // status [8] info0 detected
    localparam int ST_SIG_BIT = 9;     // status [9] line signal present
    localparam int ST_LOCK_BIT = 10;   // status [10] frame lock
    localparam int CFG_HOLD_BIT = 0;   // config [0] 100 ms hold before info4
    localparam int CFG_ERR_BIT = 1;    // config [1] deliver error indication
    localparam logic [1:0] CFG_RESET = 2'h2;
    localparam int EVENT_W = 5;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 8;
    localparam int GUARD_NS = 250_000;          // least gap info0 seen -> info2 sent
    localparam int HOLD_MS = 100;               // optional info4 hold-off
    localparam int GUARD_CYCLES = (GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYCLES = (HOLD_MS * 1_000_000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T2_MS = 0;                   // pending-deactivation timer
    localparam int T2_MIN_MS = 25;
    localparam int T2_MAX_MS = 100;
    localparam int INFO0_ONES = 48;             // ones needed to declare info0

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [2:0] {
        PWR_DOWN, G1_IDLE, G2_WAIT, G2_PEND, G2_ARMED, G3_ACTIVE, G2_GUARD
    } act_state_e;

    typedef enum logic [1:0] {
        INFO0, INFO2, INFO4
    } info_e;

    typedef struct packed {
        logic signal_present;  // energy on the line, any kind
        logic info1;           // receiver recognises info1
        logic info3;           // receiver recognises info3
        logic frame_lock;      // receive framing held
        logic bit_val;         // one received binary bit
        logic bit_valid;       // bit_val is fresh this cycle
    } line_rx_s;

    typedef struct packed {
        logic error;           // [4]
        logic deactivated;     // [3]
        logic activated;       // [2]
        logic act_pending;     // [1]
        logic line_detect;     // [0]
    } events_s;

endpackage : nt_act_pkg

//--- src/info0_detect.sv
`timescale 1ns/1ps
// counts consecutive binary ones; declares info0 once enough have arrived
module info0_detect #(
    parameter int ONES = nt_act_pkg::INFO0_ONES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // received bits
    input wire logic bit_val,
    input wire logic bit_valid,
    // result
    output logic detected
);
    localparam int CW = $clog2(ONES + 1);
    localparam logic [CW-1:0] TOP = CW'(ONES);

    initial begin
        if (ONES < 1) $error("info0_detect: ONES must be at least 1");
    end

    logic [CW-1:0] run;
    logic [CW-1:0] next_run;

    // a single zero restarts the run; the count saturates at the threshold
    always_comb begin
        next_run = run;
        if (bit_valid) begin
            if (!bit_val) next_run = '0;
            else if (run != TOP) next_run = run + CW'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) run <= '0;
        else run <= next_run;
    end

    assign detected = (run == TOP);
endmodule : info0_detect

//--- src/delay_timer.sv
`timescale 1ns/1ps
// one-shot down counter: load restarts it, done holds once it has run out
module delay_timer #(
    parameter int CYCLES = 16,
    parameter int W = 24
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic load,
    // result
    output logic done
);
    initial begin
        if (CYCLES < 1 || CYCLES >= (1 << W)) $error("delay_timer: CYCLES does not fit W");
    end

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    // counting to zero rather than up avoids a wide compare per cycle
    always_comb begin
        next_count = count;
        if (load) next_count = W'(CYCLES);
        else if (count != '0) next_count = count - W'(1);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) count <= '0;
        else count <= next_count;
    end

    assign done = (count == '0) && !load;
endmodule : delay_timer

//--- bench/nt_act_asserts.sv
`timescale 1ns/1ps
module nt_act_asserts (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // line and attention
    input wire nt_act_pkg::line_rx_s line_rx,
    input wire nt_act_pkg::info_e tx_info,
    input wire logic irq
);
    // ****
    // one clock domain
    // ****
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // writes need no wait, reads exactly one
    AST_WR_NOWAIT:
    assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    AST_RD_WAIT:
    assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    AST_OKAY:
    assert property (hresp == 1'b0) else $error("error response seen");
    // line levels move only along legal paths; info3 while info2 is sent raises attention
    AST_INFO4_ENTRY:
    assert property ($changed(tx_info) && tx_info == 2'h2 |-> $past(tx_info) == 2'h1)
        else $error("info4 not entered from info2");
    AST_NO_4_TO_2:
    assert property ($changed(tx_info) && tx_info == 2'h1 |-> $past(tx_info) != 2'h2)
        else $error("info2 straight after info4");
    AST_LOCK_LOSS:
    assert property (tx_info == 2'h2 && !line_rx.frame_lock |=> tx_info == 2'h0)
        else $error("framing loss ignored");
    AST_AP_IRQ:
    assert property (tx_info == 2'h1 && $rose(line_rx.info3) |=> irq)
        else $error("no attention on info3");
    // the guard after a loss keeps info0 for a while
    AST_GUARD:
    assert property (tx_info == 2'h0 && $past(tx_info) == 2'h2 && !$past(line_rx.frame_lock)
        |-> (tx_info == 2'h0) [*8]) else $error("guard cut short");
endmodule : nt_act_asserts

bind nt_activation_fsm nt_act_asserts i_chk (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .line_rx(line_rx), .tx_info(tx_info), .irq(irq));

//--- bench/te_model.sv
`timescale 1ns/1ps
// terminal across the loop; mode 0 silent, 1 info1, 2 info3, 3 ones,
// 4 framing lost, 5 zeros
module te_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // what to send and what the network sends
    input wire logic [2:0] mode,
    input wire nt_act_pkg::info_e tx_info,
    // line as the receiver sees it
    output nt_act_pkg::line_rx_s line_rx
);
    logic last;
    logic rnd;
    int seed = 32'h1234_5678;
    // fresh bit each cycle; last value kept to invert when idle
    always @(posedge sys_clk) begin
        rnd <= 1'($random(seed));
        last <= rst ? 1'b0 : line_rx.bit_val;
    end
    // silent line shows a toggling pattern, never a held value
    always_comb begin
        line_rx.signal_present = mode != 3'h0;
        line_rx.info1 = mode == 3'h1;
        line_rx.info3 = mode == 3'h2 && tx_info != nt_act_pkg::INFO0;
        line_rx.frame_lock = mode >= 3'h2 && mode != 3'h4;
        line_rx.bit_valid = mode >= 3'h2;
        line_rx.bit_val = mode == 3'h3 ? 1'b1 : mode == 3'h5 ? 1'b0 : mode >= 3'h2 ? rnd : !last;
    end
endmodule : te_model

//--- bench/nt_activation_fsm_tb_top.sv
`timescale 1ns/1ps
module nt_activation_fsm_tb_top;
    // ****
    // signals
    // ****
    logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize, te_mode, s;
    logic [7:0] c;
    logic [7:0] codes [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
    nt_act_pkg::line_rx_s line_rx;
    nt_act_pkg::info_e tx_info;
    int bad_count = 0;
    int compares = 0;
    int seed = 32'h5f6e_a77b;
    int n;
    time t1;
    localparam int T1_NS = 20_000;  // bench's supervisory activation limit, generous on purpose

    // short guard and hold keep the run brief
    nt_activation_fsm #(.GUARD_CYCLES(20), .HOLD_CYCLES(50)) i_dut (.sys_clk(sys_clk),
        .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .line_rx(line_rx), .tx_info(tx_info), .irq(irq));
    te_model i_te (.sys_clk(sys_clk), .rst(rst), .mode(te_mode), .tx_info(tx_info),
        .line_rx(line_rx));

    // ****
    // tasks
    // ****
    // single transfer; address held until ready, data taken at ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= 32'(a);
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) @(posedge sys_clk);
        r = hrdata;
    endtask : bus
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] b);
        bus(1'b1, nt_act_pkg::REG_CMD, 32'(b));
    endtask : cmd
    // state code and line level from the status word
    task automatic chk(input logic [2:0] st, input logic [1:0] t);
        bus(1'b0, nt_act_pkg::REG_STATUS, $random(seed));
        check(32'({r[5:4], r[2:0]}), 32'({t, st}));
    endtask : chk
    task automatic ev(input logic [4:0] e);
        bus(1'b0, nt_act_pkg::REG_EVENT, $random(seed));
        check(32'(r[4:0]), 32'(e));
    endtask : ev
    // counts cycles until the line level arrives; watchdog bounds it
    task automatic tx_wait(input logic [1:0] v);
        n = 0;
        while (tx_info !== v) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : tx_wait
    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // expected state after a command on a silent line
    function automatic logic [2:0] nxt(input logic [2:0] st, input logic [7:0] b);
        nxt = st;
        if (b == 8'h01 && st == 3'h0) nxt = 3'h1;
        if (b == 8'h02 && st == 3'h1) nxt = 3'h0;
        if (b == 8'h03 && st == 3'h1) nxt = 3'h2;
        if (b == 8'h04 && st == 3'h2) nxt = 3'h1;
    endfunction : nxt

    // ****
    // clock, watchdog, sequence
    // ****
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        conclude();
    end
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata, te_mode} = {1'b1, 71'h0};
        hsize = 3'h2;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        bus(1'b0, nt_act_pkg::REG_CONFIG, 32'h0);
        check(r, 32'h2);
        bus(1'b1, 8'h10, $random(seed));
        bus(1'b0, 8'h10, 32'h0);
        check(r, 32'h0);
        te_mode <= 3'h1;
        ev(5'h01);
        chk(3'h0, 2'h0);
        ev(5'h00);
        cmd(8'h03);
        chk(3'h0, 2'h0);
        cmd(8'h01);
        chk(3'h1, 2'h0);
        te_mode <= 3'h0;
        repeat (2) @(posedge sys_clk);
        te_mode <= 3'h1;
        repeat (2) @(posedge sys_clk);
        check(32'(irq), 32'h1);
        ev(5'h01);
        check(32'(irq), 32'h0);
        cmd(8'h03);
        t1 = $time;
        chk(3'h2, 2'h1);
        te_mode <= 3'h2;
        ev(5'h02);
        chk(3'h3, 2'h1);
        cmd(8'h03);
        chk(3'h5, 2'h2);
        ev(5'h04);
        check(32'($time - t1 < T1_NS), 32'h1);
        // ones broken by zeros must not count as info0; zeros first clear any random run
        te_mode <= 3'h5;
        repeat (2) @(posedge sys_clk);
        te_mode <= 3'h3;
        repeat (40) @(posedge sys_clk);
        te_mode <= 3'h5;
        repeat (2) @(posedge sys_clk);
        te_mode <= 3'h3;
        repeat (40) @(posedge sys_clk);
        check(32'(tx_info), 32'h2);
        tx_wait(2'h0);
        check(32'(n >= nt_act_pkg::INFO0_ONES - 40), 32'h1);
        tx_wait(2'h1);
        check(32'(n >= 20), 32'h1);
        ev(5'h18);
        chk(3'h2, 2'h1);
        // hold before info4, error reports off
        bus(1'b1, nt_act_pkg::REG_CONFIG, 32'h1);
        te_mode <= 3'h2;
        repeat (2) @(posedge sys_clk);
        cmd(8'h03);
        chk(3'h4, 2'h1);
        tx_wait(2'h2);
        ev(5'h06);
        te_mode <= 3'h4;
        tx_wait(2'h0);
        ev(5'h00);
        tx_wait(2'h1);
        chk(3'h2, 2'h1);
        cmd(8'h04);
        chk(3'h1, 2'h0);
        ev(5'h08);
        cmd(8'h02);
        chk(3'h0, 2'h0);
        te_mode <= 3'h0;
        // random commands, valid and invalid, on a silent line
        s = 3'h0;
        for (int i = 0; i < 24; i++) begin
            n = $random(seed);
            c = n[8] ? codes[n[1:0]] : n[7:0];
            s = nxt(s, c);
            cmd(c);
            chk(s, s == 3'h2 ? 2'h1 : 2'h0);
        end
        conclude();
    end
endmodule : nt_activation_fsm_tb_top
